// ==== logic/sector_protect_and_training_regs.sv ====
`timescale 1ns/100ps
// Functional notes
// RULE1: mode bit 2 at zero fixes secret-key protection mode for good.
// RULE2: mode bit 1 at zero fixes nonvolatile protection mode for good.
// RULE3: mode bits 8,7,5,4,3 reset to a per-variant factory option.
// RULE4: 64-bit one-time hidden key, all ones when unprogrammed.
// RULE5: once mode bit 2 is zero, key reads never return the key.
// RULE6: array lock bit zero refuses persistent bit program and erase.
// RULE7: lock resets to one in nonvolatile mode; upper seven bits read zero.
// RULE8: persistent bit zero reads 00h and blocks sector program/erase.
// RULE9: persistent bit one reads FFh, sector open; erased is default.
// RULE10: dynamic write of 00h clears the sector bit and blocks the sector.
// RULE11: dynamic write of FFh sets the sector bit and opens the sector.
// RULE12: one-time training pattern, default 00h, may go out in dummy cycles.
// RULE13: any reset loads the working pattern from the stored pattern.
// RULE14: outputs take the working pattern, which also enables delivery.
// RULE15: host may rewrite working pattern anytime; stored copy unchanged.
// RULE16: host uses the pattern to centre its data capture point.
// RULE17: mode register ships with variant value FE7Fh.
// RULE18: one-time bits only fall from one to zero, never rise again.
module sector_protect_and_training_regs
    import prot_pkg::*;
#(
    parameter logic [15:0] MODE_FACTORY = MODE_SEL_FACTORY
) (
    // system clock and resets
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              por_rst,
    // sector permission query
    input  wire logic [SECT_W-1:0] chk_sector,
    output logic                   chk_allow,
    // protection mode flags
    output logic                   secret_mode_on,
    output logic                   nvmode_fixed,
    // link clock and register requests
    input  wire logic              sck,
    input  wire logic              lk_req_valid,
    input  wire logic [OP_W-1:0]   lk_req_op,
    input  wire logic [SECT_W-1:0] lk_req_sector,
    input  wire logic [63:0]       lk_req_data,
    output logic                   lk_req_ready,
    // link responses
    output logic                   lk_rsp_valid,
    output logic [63:0]            lk_rsp_data,
    output logic                   lk_rsp_refused,
    // training pattern delivery
    input  wire logic              lk_dummy,
    output logic [3:0]             io_out,
    output logic [3:0]             io_oe
);

    typedef enum logic {ST_IDLE, ST_SEND} sys_st_t;

    localparam logic [15:0] MODE_RST = MODE_FIXED_ONES
                                     | (MODE_FACTORY & MODE_OPT_MASK);

    logic              rst_any;
    logic              rst_any_r;
    logic              lk_rst;
    logic              lk_rst_s;
    logic              xfer_rst;
    logic              rq_dv;
    logic [REQ_W-1:0]  rq_dd;
    op_t               rq_op;
    logic [SECT_W-1:0] rq_sect;
    logic [63:0]       rq_wdata;
    logic              rq_ready;
    logic              rsp_ready;
    logic              rsp_dv;
    logic [RSP_W-1:0]  rsp_dd;
    sys_st_t           state_r;
    logic              go;
    logic              push_r;
    logic              rsp_ref_r;
    logic [63:0]       rsp_data_r;
    logic [15:0]       mode_sel_r;
    logic [63:0]       key_r;
    logic              lock_r;
    logic [7:0]        spat_r;
    logic [7:0]        wpat_r;
    logic              psb_r [SECTORS];
    logic              dsb_r [SECTORS];
    logic              psb_cur;
    logic              dsb_cur;
    logic [63:0]       data_nxt;
    logic              ref_nxt;
    logic              mode_pg;
    logic              key_pg;
    logic              lock_clr;
    logic              psb_pg;
    logic              psb_ers;
    logic              dsb_clr;
    logic              dsb_set;
    logic              spat_pg;
    logic              wpat_wr;
    logic [15:0]       mode_new;
    logic              lk_busy_r;
    logic [7:0]        pat_lk_r;
    logic [2:0]        bit_cnt_r;

    assign rst_any  = sys_rst | por_rst;
    assign rq_op    = op_t'(rq_dd[REQ_W-1 -: OP_W]);
    assign rq_sect  = rq_dd[DATA_W +: SECT_W];
    assign rq_wdata = rq_dd[DATA_W-1:0];
    assign psb_cur  = psb_r[rq_sect];
    assign dsb_cur  = dsb_r[rq_sect];
    assign go       = (state_r == ST_IDLE) && rq_dv;
    assign mode_new = mode_sel_r & rq_wdata[15:0];

    // reset held until the link side has seen it; a short pulse
    // would otherwise slip between two slow sck edges
    always_ff @(posedge clk) begin
        if (rst_any) begin
            rst_any_r <= 1'b1;
        end else if (lk_rst_s) begin
            rst_any_r <= 1'b0;
        end
    end

    bit_sync u_lk_rst (
        .clk (sck),
        .rst (1'b0),
        .d   (rst_any_r),
        .q   (lk_rst)
    );

    bit_sync u_lk_rst_back (
        .clk (clk),
        .rst (1'b0),
        .d   (lk_rst),
        .q   (lk_rst_s)
    );

    // crossings and sequencer stay reset until both sides are out,
    // so no stale toggle replays an old request or answer
    assign xfer_rst = rst_any | rst_any_r | lk_rst_s;

    word_xfer #(.W(REQ_W)) u_req_xfer (
        .src_clk   (sck),
        .src_rst   (lk_rst),
        .src_valid (lk_req_valid && lk_req_ready),
        .src_data  ({lk_req_op, lk_req_sector, lk_req_data}),
        .src_ready (rq_ready),
        .dst_clk   (clk),
        .dst_rst   (xfer_rst),
        .dst_valid (rq_dv),
        .dst_data  (rq_dd)
    );

    word_xfer #(.W(RSP_W)) u_rsp_xfer (
        .src_clk   (clk),
        .src_rst   (xfer_rst),
        .src_valid (state_r == ST_SEND),
        .src_data  ({push_r, rsp_ref_r, wpat_r, rsp_data_r}),
        .src_ready (rsp_ready),
        .dst_clk   (sck),
        .dst_rst   (lk_rst),
        .dst_valid (rsp_dv),
        .dst_data  (rsp_dd)
    );

    // command decode: read data, refusal and write strobes
    always_comb begin
        data_nxt = '0;
        ref_nxt  = 1'b0;
        mode_pg  = 1'b0;
        key_pg   = 1'b0;
        lock_clr = 1'b0;
        psb_pg   = 1'b0;
        psb_ers  = 1'b0;
        dsb_clr  = 1'b0;
        dsb_set  = 1'b0;
        spat_pg  = 1'b0;
        wpat_wr  = 1'b0;
        case (rq_op)
            OP_RD_MODE: data_nxt = {48'h0, mode_sel_r};
            OP_PG_MODE: begin
                // both mode locks at zero would be contradictory
                if (!mode_new[SECRET_LOCK_POS]
                        && !mode_new[NVMODE_LOCK_POS]) begin
                    ref_nxt = 1'b1;
                end else begin
                    mode_pg = 1'b1;
                end
                data_nxt = {48'h0, mode_sel_r};
            end
            OP_RD_KEY: begin
                if (!mode_sel_r[SECRET_LOCK_POS]) begin // RULE5
                    data_nxt = KEY_ERASED;
                    ref_nxt  = 1'b1;
                end else begin
                    data_nxt = key_r;
                end
            end
            OP_PG_KEY: begin
                ref_nxt = !mode_sel_r[SECRET_LOCK_POS];
                key_pg  = mode_sel_r[SECRET_LOCK_POS];
            end
            OP_RD_LOCK:  data_nxt = {56'h0, 7'h00, lock_r}; // RULE7
            OP_CLR_LOCK: lock_clr = 1'b1;
            OP_RD_PSB: begin
                data_nxt = {56'h0, psb_cur ? SECT_OPEN : SECT_PROT}; // RULE8
            end
            OP_PG_PSB: begin
                ref_nxt = !lock_r; // RULE6
                psb_pg  = lock_r;
            end
            OP_ERS_PSB: begin
                ref_nxt = !lock_r; // RULE6
                psb_ers = lock_r;
            end
            OP_RD_DSB: begin
                data_nxt = {56'h0, dsb_cur ? SECT_OPEN : SECT_PROT};
            end
            OP_WR_DSB: begin
                // only the two defined codes mean anything
                if (rq_wdata[7:0] == SECT_PROT) begin
                    dsb_clr = 1'b1; // RULE10
                end else if (rq_wdata[7:0] == SECT_OPEN) begin
                    dsb_set = 1'b1; // RULE11
                end else begin
                    ref_nxt = 1'b1;
                end
            end
            OP_RD_SPAT: data_nxt = {56'h0, spat_r};
            OP_PG_SPAT: spat_pg  = 1'b1;
            OP_RD_WPAT: data_nxt = {56'h0, wpat_r};
            OP_WR_WPAT: wpat_wr  = 1'b1;
            default:    ref_nxt  = 1'b1;
        endcase
    end

    // request/response sequencing; reset pushes the pattern to the link
    always_ff @(posedge clk) begin
        if (xfer_rst) begin
            state_r    <= ST_SEND;
            push_r     <= 1'b1;
            rsp_ref_r  <= 1'b0;
            rsp_data_r <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (rq_dv) begin
                        state_r    <= ST_SEND;
                        push_r     <= 1'b0;
                        rsp_ref_r  <= ref_nxt;
                        rsp_data_r <= data_nxt;
                    end
                end
                ST_SEND: begin
                    if (rsp_ready) begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // one-time mode select; only power-on restores the factory value
    always_ff @(posedge clk) begin
        if (por_rst) begin
            mode_sel_r <= MODE_RST; // RULE3 RULE17
        end else if (go && mode_pg) begin
            mode_sel_r <= mode_new; // RULE18
        end
    end

    // one-time hidden key, bits can only be cleared
    always_ff @(posedge clk) begin
        if (por_rst) begin
            key_r <= KEY_ERASED; // RULE4
        end else if (go && key_pg) begin
            key_r <= key_r & rq_wdata; // RULE18
        end
    end

    // volatile array lock; set again only by a reset
    always_ff @(posedge clk) begin
        if (por_rst) begin
            lock_r <= MODE_RST[SECRET_LOCK_POS] ? LOCK_RESET_PERSIST
                                                : LOCK_RESET_SECRET;
        end else if (sys_rst) begin
            lock_r <= mode_sel_r[SECRET_LOCK_POS] ? LOCK_RESET_PERSIST
                                                  : LOCK_RESET_SECRET; // RULE7
        end else if (go && lock_clr) begin
            lock_r <= 1'b0; // RULE6
        end
    end

    // stored and working training patterns
    always_ff @(posedge clk) begin
        if (por_rst) begin
            spat_r <= SPAT_RESET; // RULE12
        end else if (go && spat_pg) begin
            spat_r <= spat_r & rq_wdata[7:0]; // RULE18
        end
    end

    always_ff @(posedge clk) begin
        if (por_rst) begin
            wpat_r <= SPAT_RESET;
        end else if (sys_rst) begin
            wpat_r <= spat_r; // RULE13
        end else if (go && wpat_wr) begin
            wpat_r <= rq_wdata[7:0]; // RULE15
        end
    end

    // per-sector nonvolatile and volatile protection bits
    for (genvar s = 0; s < SECTORS; s++) begin : g_sect
        always_ff @(posedge clk) begin
            if (por_rst) begin
                psb_r[s] <= 1'b1; // RULE9
            end else if (go && psb_pg && rq_sect == SECT_W'(s)) begin
                psb_r[s] <= 1'b0; // RULE8
            end else if (go && psb_ers) begin
                psb_r[s] <= 1'b1;
            end
        end
        always_ff @(posedge clk) begin
            if (rst_any) begin
                dsb_r[s] <= 1'b1;
            end else if (go && rq_sect == SECT_W'(s)) begin
                if (dsb_clr) begin
                    dsb_r[s] <= 1'b0; // RULE10
                end else if (dsb_set) begin
                    dsb_r[s] <= 1'b1; // RULE11
                end
            end
        end
    end

    // sector permission and mode flags, registered
    always_ff @(posedge clk) begin
        if (rst_any) begin
            chk_allow      <= 1'b0;
            secret_mode_on <= 1'b0;
            nvmode_fixed   <= 1'b0;
        end else begin
            chk_allow      <= psb_r[chk_sector] && dsb_r[chk_sector]; // RULE8
            secret_mode_on <= !mode_sel_r[SECRET_LOCK_POS]; // RULE1
            nvmode_fixed   <= !mode_sel_r[NVMODE_LOCK_POS]; // RULE2
        end
    end

    // link side: one request outstanding until its answer returns
    assign lk_req_ready = rq_ready && !lk_busy_r;

    always_ff @(posedge sck) begin
        if (lk_rst) begin
            lk_busy_r      <= 1'b0;
            lk_rsp_valid   <= 1'b0;
            lk_rsp_data    <= '0;
            lk_rsp_refused <= 1'b0;
            pat_lk_r       <= SPAT_RESET;
        end else begin
            lk_rsp_valid <= rsp_dv && !rsp_dd[RSP_W-1];
            if (lk_req_valid && lk_req_ready) begin
                lk_busy_r <= 1'b1;
            end else if (rsp_dv && !rsp_dd[RSP_W-1]) begin
                lk_busy_r <= 1'b0;
            end
            if (rsp_dv) begin
                pat_lk_r <= rsp_dd[DATA_W +: 8]; // RULE14
                if (!rsp_dd[RSP_W-1]) begin
                    lk_rsp_data    <= rsp_dd[DATA_W-1:0];
                    lk_rsp_refused <= rsp_dd[RSP_W-2];
                end
            end
        end
    end

    // pattern shifted msb first on all lanes; 00h turns delivery off
    always_ff @(posedge sck) begin
        if (lk_rst || !lk_dummy) begin
            bit_cnt_r <= 3'h0;
            io_out    <= 4'h0;
            io_oe     <= 4'h0;
        end else begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            io_out    <= {4{pat_lk_r[3'h7 - bit_cnt_r]}}; // RULE14
            io_oe     <= {4{pat_lk_r != 8'h00}}; // RULE12
        end
    end

    a_key_hidden: assert property (@(posedge clk) disable iff (rst_any)
        go && rq_op == OP_RD_KEY && !mode_sel_r[SECRET_LOCK_POS]
        |=> rsp_data_r == KEY_ERASED && rsp_ref_r) // RULE5
        else $error("key visible after secret mode lock");

    a_lock_refuses_psb: assert property (@(posedge clk) disable iff (rst_any)
        go && (rq_op == OP_PG_PSB || rq_op == OP_ERS_PSB) && !lock_r
        |=> rsp_ref_r && $stable(psb_cur)) // RULE6
        else $error("persistent bits changed while locked");

    a_mode_no_rise: assert property (@(posedge clk) disable iff (por_rst)
        (mode_sel_r & ~$past(mode_sel_r)) == 16'h0000) // RULE18
        else $error("one-time mode bit rose");

    a_spat_no_rise: assert property (@(posedge clk) disable iff (por_rst)
        (spat_r & ~$past(spat_r)) == 8'h00) // RULE18
        else $error("one-time pattern bit rose");

    a_lock_reset_val: assert property (@(posedge clk) disable iff (por_rst)
        sys_rst ##1 !sys_rst
        |-> lock_r == mode_sel_r[SECRET_LOCK_POS]) // RULE7
        else $error("lock wrong after reset");

    a_wpat_reload: assert property (@(posedge clk) disable iff (por_rst)
        sys_rst |=> wpat_r == $past(spat_r)) // RULE13
        else $error("working pattern not reloaded");

    a_psb_read_code: assert property (@(posedge clk) disable iff (rst_any)
        go && rq_op == OP_RD_PSB
        |=> rsp_data_r[7:0]
            == ($past(psb_cur) ? SECT_OPEN : SECT_PROT)) // RULE9
        else $error("persistent bit read code wrong");

    a_dsb_clear: assert property (@(posedge clk) disable iff (rst_any)
        go && rq_op == OP_WR_DSB && rq_wdata[7:0] == SECT_PROT
        |=> !dsb_cur ##1 !chk_allow || chk_sector != rq_sect) // RULE10
        else $error("dynamic clear failed");

    a_dsb_set: assert property (@(posedge clk) disable iff (rst_any)
        go && rq_op == OP_WR_DSB && rq_wdata[7:0] == SECT_OPEN
        |=> dsb_cur) // RULE11
        else $error("dynamic set failed");

    a_pattern_oe: assert property (@(posedge sck) disable iff (lk_rst)
        lk_dummy && pat_lk_r == 8'h00 |=> io_oe == 4'h0) // RULE14
        else $error("pattern driven while disabled");

    c_key_read: cover property (@(posedge clk) disable iff (rst_any)
        go && rq_op == OP_RD_KEY);
    c_psb_prog: cover property (@(posedge clk) disable iff (rst_any)
        go && rq_op == OP_PG_PSB && lock_r);
    c_train_out: cover property (@(posedge sck) disable iff (lk_rst)
        io_oe == 4'hF);

endmodule

// ==== include/prot_pkg.sv ====
package prot_pkg;

    // sector geometry of the protection arrays
    localparam int SECTORS = 64;
    localparam int SECT_W  = 6;

    // protection mode select layout and values
    localparam logic [15:0] MODE_SEL_FACTORY = 16'hFE7F;
    localparam logic [15:0] MODE_FIXED_ONES  = 16'hFE47;
    localparam logic [15:0] MODE_OPT_MASK    = 16'h01B8;
    localparam int          SECRET_LOCK_POS  = 2;
    localparam int          NVMODE_LOCK_POS  = 1;

    // hidden key and lock values
    localparam logic [63:0] KEY_ERASED         = 64'hFFFF_FFFF_FFFF_FFFF;
    localparam logic        LOCK_RESET_PERSIST = 1'b1;
    localparam logic        LOCK_RESET_SECRET  = 1'b0;

    // per-sector access codes
    localparam logic [7:0] SECT_PROT = 8'h00;
    localparam logic [7:0] SECT_OPEN = 8'hFF;

    // training pattern reset value
    localparam logic [7:0] SPAT_RESET = 8'h00;

    // link request and response word layout
    localparam int OP_W   = 4;
    localparam int DATA_W = 64;
    localparam int REQ_W  = OP_W + SECT_W + DATA_W;
    localparam int RSP_W  = 2 + 8 + DATA_W;

    // register access commands carried over the link
    typedef enum logic [OP_W-1:0] {
        OP_RD_MODE,
        OP_PG_MODE,
        OP_RD_KEY,
        OP_PG_KEY,
        OP_RD_LOCK,
        OP_CLR_LOCK,
        OP_RD_PSB,
        OP_PG_PSB,
        OP_ERS_PSB,
        OP_RD_DSB,
        OP_WR_DSB,
        OP_RD_SPAT,
        OP_PG_SPAT,
        OP_RD_WPAT,
        OP_WR_WPAT
    } op_t;

endpackage

// ==== logic/bit_sync.sv ====
`timescale 1ns/100ps
module bit_sync (
    // destination clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // level in, synchronised level out
    input  wire logic d,
    output logic      q
);

    logic meta_r;

    // two stages; the first is read only by the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= 1'b0;
            q      <= 1'b0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

// ==== logic/word_xfer.sv ====
`timescale 1ns/100ps
module word_xfer #(
    parameter int W = 8
) (
    // source domain
    input  wire logic         src_clk,
    input  wire logic         src_rst,
    input  wire logic         src_valid,
    input  wire logic [W-1:0] src_data,
    output logic              src_ready,
    // destination domain
    input  wire logic         dst_clk,
    input  wire logic         dst_rst,
    output logic              dst_valid,
    output logic [W-1:0]      dst_data
);

    logic         req_tgl_r;
    logic         ack_s;
    logic         req_s;
    logic         seen_r;
    logic [W-1:0] hold_r;

    // one word in flight; held stable until the toggle comes back
    assign src_ready = (req_tgl_r == ack_s);

    // source toggle and held word
    always_ff @(posedge src_clk) begin
        if (src_rst) begin
            req_tgl_r <= 1'b0;
            hold_r    <= '0;
        end else if (src_valid && src_ready) begin
            req_tgl_r <= ~req_tgl_r;
            hold_r    <= src_data;
        end
    end

    bit_sync u_req (
        .clk (dst_clk),
        .rst (dst_rst),
        .d   (req_tgl_r),
        .q   (req_s)
    );

    // destination edge detect and capture of the stable word
    always_ff @(posedge dst_clk) begin
        if (dst_rst) begin
            seen_r    <= 1'b0;
            dst_valid <= 1'b0;
            dst_data  <= '0;
        end else begin
            seen_r    <= req_s;
            dst_valid <= (req_s != seen_r);
            if (req_s != seen_r) begin
                dst_data <= hold_r;
            end
        end
    end

    bit_sync u_ack (
        .clk (src_clk),
        .rst (src_rst),
        .d   (seen_r),
        .q   (ack_s)
    );

endmodule

// ==== verif/host_model.sv ====
`timescale 1ns/100ps
module host_model
    import prot_pkg::*;
(
    // link clock
    input  wire logic              sck,
    // request side
    output logic                   lk_req_valid,
    output logic [OP_W-1:0]        lk_req_op,
    output logic [SECT_W-1:0]      lk_req_sector,
    output logic [63:0]            lk_req_data,
    input  wire logic              lk_req_ready,
    // answer side
    input  wire logic              lk_rsp_valid,
    input  wire logic [63:0]       lk_rsp_data,
    input  wire logic              lk_rsp_refused,
    // training lanes
    output logic                   lk_dummy,
    input  wire logic [3:0]        io_out,
    input  wire logic [3:0]        io_oe
);
    initial begin
        lk_req_valid  = 1'b0;
        lk_req_op     = '0;
        lk_req_sector = '0;
        lk_req_data   = '0;
        lk_dummy      = 1'b0;
    end

    // one request outstanding, held until taken, then answer awaited
    task automatic xfer(input logic [OP_W-1:0] op, input logic [SECT_W-1:0] s,
        input logic [63:0] d, output logic [63:0] q, output logic rf,
        output logic ok);
        int n;
        n = 0;
        @(posedge sck);
        lk_req_valid  <= 1'b1;
        lk_req_op     <= op;
        lk_req_sector <= s;
        lk_req_data   <= d;
        do begin
            @(posedge sck);
            n++;
        end while (lk_req_ready !== 1'b1 && n < 20);
        // released lines flip so no stale copy looks valid
        lk_req_valid  <= 1'b0;
        lk_req_op     <= ~op;
        lk_req_sector <= ~s;
        lk_req_data   <= ~d;
        n = 0;
        do begin
            @(posedge sck);
            n++;
        end while (lk_rsp_valid !== 1'b1 && n < 20);
        ok = (lk_rsp_valid === 1'b1);
        q  = lk_rsp_data;
        rf = lk_rsp_refused;
    endtask

    // eight dummy bits, msb first; lane enables gathered alongside
    task automatic learn(output logic [7:0] p, output logic [3:0] oe);
        @(posedge sck);
        lk_dummy <= 1'b1;
        @(posedge sck);
        oe = 4'hF;
        for (int i = 7; i >= 0; i--) begin
            @(posedge sck);
            p[i] = io_out[0];
            oe   = oe & io_oe;
        end
        lk_dummy <= 1'b0;
    endtask
endmodule

// ==== verif/testbench.sv ====
`timescale 1ns/100ps
module testbench
    import prot_pkg::*;
();
    logic              clk, sys_rst, por_rst, sck, lk_dummy;
    logic              chk_allow, secret_mode_on, nvmode_fixed;
    logic              lk_req_valid, lk_req_ready, lk_rsp_valid;
    logic              lk_rsp_refused;
    logic [SECT_W-1:0] chk_sector, lk_req_sector, s;
    logic [OP_W-1:0]   lk_req_op;
    logic [63:0]       lk_req_data, lk_rsp_data, k, m;
    logic [7:0]        w;
    logic [3:0]        io_out, io_oe;
    int                n_mismatch, n_checks, seed;

    sector_protect_and_training_regs u_dut (.clk, .sys_rst, .por_rst,
        .chk_sector, .chk_allow, .secret_mode_on, .nvmode_fixed, .sck,
        .lk_req_valid, .lk_req_op, .lk_req_sector, .lk_req_data,
        .lk_req_ready, .lk_rsp_valid, .lk_rsp_data, .lk_rsp_refused,
        .lk_dummy, .io_out, .io_oe);
    host_model u_host (.sck, .lk_req_valid, .lk_req_op, .lk_req_sector,
        .lk_req_data, .lk_req_ready, .lk_rsp_valid, .lk_rsp_data,
        .lk_rsp_refused, .lk_dummy, .io_out, .io_oe);

    // clocks, link clock phase unrelated to the system clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        sck = 1'b0;
        #37;
        forever #80 sck = ~sck;
    end

    // one-time bits can only fall
    function automatic logic [63:0] fall(input logic [63:0] o, d);
        return o & d;
    endfunction

    task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // refused answers carry no defined data except for key reads
    task run(input logic [OP_W-1:0] o, input logic [63:0] d, e,
        input logic er);
        logic [63:0] q;
        logic        rf, ok;
        u_host.xfer(o, s, d, q, rf, ok);
        chk("answer", 64'h1, 64'(ok));
        chk("refused", 64'(er), 64'(rf));
        if (!er || o == OP_RD_KEY) chk("rsp_data", e, q);
    endtask

    task allow(input logic [SECT_W-1:0] x, input logic e);
        @(posedge clk);
        chk_sector <= x;
        repeat (3) @(posedge clk);
        chk("chk_allow", 64'(e), 64'(chk_allow));
    endtask

    task pat(input logic [7:0] e, input logic [3:0] eo);
        logic [7:0] p;
        logic [3:0] oe;
        u_host.learn(p, oe);
        chk("pattern", 64'(e), 64'(p));
        chk("lane_oe", 64'(eo), 64'(oe));
    endtask

    // link side needs settled sck edges after release
    task rst(input logic por);
        @(posedge clk);
        sys_rst <= 1'b1;
        por_rst <= por;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        por_rst <= 1'b0;
        repeat (16) @(posedge sck);
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // watchdog, about eight times the expected run
    initial begin
        #500000;
        n_mismatch++;
        test_done;
    end

    initial begin
        seed = 38115;
        n_mismatch = 0;
        n_checks = 0;
        sys_rst = 1'b1;
        por_rst = 1'b1;
        chk_sector = '0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        por_rst <= 1'b0;
        repeat (16) @(posedge sck);
        s = 6'($random(seed));
        m = 64'(MODE_SEL_FACTORY);
        // reset values
        run(OP_RD_MODE, 0, m, 0);
        chk("flags", 0, 64'({secret_mode_on, nvmode_fixed}));
        run(OP_RD_KEY, 0, KEY_ERASED, 0);
        run(OP_RD_LOCK, 0, 64'h1, 0);
        run(OP_RD_PSB, 0, 64'(SECT_OPEN), 0);
        run(OP_RD_DSB, 0, 64'(SECT_OPEN), 0);
        run(OP_RD_SPAT, 0, 64'(SPAT_RESET), 0);
        run(OP_RD_WPAT, 0, 64'(SPAT_RESET), 0);
        pat(SPAT_RESET, 4'h0);
        allow(s, 1'b1);
        run(4'hF, 0, 0, 1);
        $display("test reset done");
        // dynamic bits, neighbour sector must stay open
        run(OP_WR_DSB, 64'(SECT_PROT), 0, 0);
        run(OP_RD_DSB, 0, 64'(SECT_PROT), 0);
        allow(s, 1'b0);
        allow(s ^ 6'h01, 1'b1);
        run(OP_WR_DSB, 64'h5A, 0, 1);
        run(OP_WR_DSB, 64'(SECT_OPEN), 0, 0);
        allow(s, 1'b1);
        $display("test dynamic done");
        // persistent bits and the array lock
        run(OP_PG_PSB, 0, 0, 0);
        run(OP_RD_PSB, 0, 64'(SECT_PROT), 0);
        allow(s, 1'b0);
        run(OP_ERS_PSB, 0, 0, 0);
        run(OP_RD_PSB, 0, 64'(SECT_OPEN), 0);
        run(OP_CLR_LOCK, 0, 0, 0);
        run(OP_RD_LOCK, 0, 0, 0);
        run(OP_PG_PSB, 0, 0, 1);
        run(OP_RD_PSB, 0, 64'(SECT_OPEN), 0);
        $display("test persistent done");
        // working pattern versus stored pattern
        w = 8'($random(seed)) | 8'h01;
        run(OP_WR_WPAT, 64'(w), 0, 0);
        run(OP_RD_WPAT, 0, 64'(w), 0);
        run(OP_RD_SPAT, 0, 64'(SPAT_RESET), 0);
        pat(w, 4'hF);
        k = 64'($random(seed));
        run(OP_PG_SPAT, k, 0, 0);
        run(OP_RD_SPAT, 0, fall(64'(SPAT_RESET), k), 0);
        rst(1'b0);
        run(OP_RD_WPAT, 0, fall(64'(SPAT_RESET), k), 0);
        run(OP_RD_LOCK, 0, 64'(LOCK_RESET_PERSIST), 0);
        pat(SPAT_RESET, 4'h0);
        $display("test pattern done");
        // key and mode lock bits
        k = {$random(seed), $random(seed)};
        run(OP_PG_KEY, k, 0, 0);
        run(OP_RD_KEY, 0, k, 0);
        run(OP_PG_MODE, 64'hFFFD, m, 0);
        m = fall(m, 64'hFFFD);
        chk("nvmode_fixed", 1, 64'(nvmode_fixed));
        run(OP_PG_MODE, 64'hFFFB, m, 1);
        run(OP_RD_MODE, 0, m, 0);
        rst(1'b1);
        m = 64'(MODE_SEL_FACTORY);
        run(OP_PG_MODE, 64'hFFFB, m, 0);
        m = fall(m, 64'hFFFB);
        run(OP_PG_MODE, 64'hFFFF, m, 0);
        run(OP_RD_MODE, 0, m, 0);
        chk("secret_mode_on", 1, 64'(secret_mode_on));
        run(OP_RD_KEY, 0, KEY_ERASED, 1);
        run(OP_PG_KEY, 0, 0, 1);
        rst(1'b0);
        run(OP_RD_LOCK, 0, 64'(LOCK_RESET_SECRET), 0);
        $display("test mode done");
        test_done;
    end
endmodule
